//--- dac_path_ctrl_defines.vh
/*
 * Constants for the playback processing-path control register bank.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DAC_PATH_CTRL_DEFINES_VH
`define DAC_PATH_CTRL_DEFINES_VH

// Register addresses on the serial control bus.
`define ADDR_BLOCK_SELECT   7'h3c
`define ADDR_RSVD_SELECT    7'h3d
`define ADDR_MODE_CONTROL   7'h3e
`define ADDR_PATH_SETUP     7'h3f
`define ADDR_VOLUME_MUTE    7'h40

// Reset values.
`define RST_BLOCK_SELECT    8'h01
`define RST_RSVD_SELECT     8'h08
`define RST_MODE_CONTROL    8'h00
`define RST_PATH_SETUP      8'h14
`define RST_VOLUME_MUTE     8'h0c
`define RST_SEL_LIVE        5'h01
`define RST_PATH_LIVE       2'h1
`define RDATA_IDLE          8'h00

// Field positions.
`define SEL_MSB             4
`define SEL_LSB             0
`define AUX_A_BIT           2
`define AUX_B_BIT           1
`define PC_FREE_BIT         0
`define POWER_BIT           7
`define PATH_MSB            5
`define PATH_LSB            4
`define STEP_MSB            1
`define STEP_LSB            0
`define MUTE_BIT            3

// Processing-select codes.
`define SEL_ENGINE          5'h00
`define SEL_BLK4            5'h04
`define SEL_BLK6            5'h06
`define SEL_BLK12           5'h0c
`define SEL_BLK16           5'h10
`define SEL_BLK20           5'h14
`define SEL_BLK22           5'h16
`define BLOCK_NONE          5'h00

// Path-select codes.
`define PATH_OFF            2'h0
`define PATH_LEFT           2'h1
`define PATH_RIGHT          2'h2
`define PATH_AVG            2'h3

// Soft-step codes.
`define STEP_EVERY          2'h0
`define STEP_EVERY_TWO      2'h1
`define STEP_NONE           2'h2
`define VOL_STEP            8'h01

`endif

//--- dac_path_ctrl.v
/*
 * Register bank steering the mono playback path: processing engine or
 * fixed block choice, engine branch conditions and counter restart,
 * power, channel mix, volume soft-stepping and mute.
 * Assumes register writes arrive as decoded address/data strobes from
 * the serial control interface, and a one-cycle frame start and sample
 * strobe from the audio clock divider, all on clock_i.
 * Read data is registered: it shows the addressed register one clock
 * after the address is presented, which the host must allow for.
 */
// Notes on behaviour
// - Select code zero routes through programmable engine.
// - Codes map onto fixed blocks 4-6, 12-16, 20-22.
// - Mode bit 2 is branch condition A.
// - Mode bit 1 is branch condition B.
// - Mode bit 0 clear restarts counter each frame.
// - Setup bit 7 powers converter; resets low.
// - Path field picks off, left, right, average.
// - Step code 00 moves one step per sample.
// - Code 01 every two samples; 10 immediate.
// - Mute bit holds output muted; resets muted.
`timescale 1ns/100ps
`default_nettype none
`include "dac_path_ctrl_defines.vh"

module dac_path_ctrl (
  // Clock and reset.
  input  wire        clock_i,
  input  wire        rstn_i,
  // Register access from the serial control interface.
  input  wire        reg_wr_i,
  input  wire [6:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  // Audio timing and samples.
  input  wire        frame_start_i,
  input  wire        sample_tick_i,
  input  wire [23:0] left_i,
  input  wire [23:0] right_i,
  // Volume request from the gain logic.
  input  wire [7:0]  volume_target_i,
  // Engine controls.
  output reg         engine_select_o,
  output reg  [4:0]  fixed_block_o,
  output reg         aux_cond_a_o,
  output reg         aux_cond_b_o,
  output reg         pc_clear_o,
  // Converter controls and data.
  output reg         power_up_o,
  output reg         mute_o,
  output reg  [23:0] mono_o,
  output reg  [7:0]  volume_now_o
);

  reg  [7:0]  block_select;
  reg  [7:0]  rsvd_select;
  reg  [7:0]  mode_control;
  reg  [7:0]  path_setup;
  reg  [7:0]  volume_mute;
  reg  [4:0]  sel_live;
  reg  [1:0]  path_live;
  reg         step_half;
  reg  [24:0] mix_sum;
  reg  [23:0] next_mono;
  reg         step_due;
  wire [4:0]  sel_new = block_select[`SEL_MSB:`SEL_LSB];
  wire [1:0]  step_code = path_setup[`STEP_MSB:`STEP_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Register writes. Every bit is stored as written, reserved bits too,
  // so reads return exactly what the host last wrote. Writes to unmapped
  // addresses are dropped.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      block_select <= `RST_BLOCK_SELECT;
      rsvd_select  <= `RST_RSVD_SELECT;
      mode_control <= `RST_MODE_CONTROL;
      path_setup   <= `RST_PATH_SETUP;  // Power bit starts low.
      volume_mute  <= `RST_VOLUME_MUTE; // Mute bit starts set.
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_BLOCK_SELECT: block_select <= reg_wdata_i;
        `ADDR_RSVD_SELECT:  rsvd_select  <= reg_wdata_i;
        `ADDR_MODE_CONTROL: mode_control <= reg_wdata_i;
        `ADDR_PATH_SETUP:   path_setup   <= reg_wdata_i;
        `ADDR_VOLUME_MUTE:  volume_mute  <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Read data register; unmapped addresses read zero. Registering it
  // keeps the read port glitch-free, at the price of one clock of delay.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `RDATA_IDLE;
    end else begin
      case (reg_addr_i)
        `ADDR_BLOCK_SELECT: reg_rdata_o <= block_select;
        `ADDR_RSVD_SELECT:  reg_rdata_o <= rsvd_select;
        `ADDR_MODE_CONTROL: reg_rdata_o <= mode_control;
        `ADDR_PATH_SETUP:   reg_rdata_o <= path_setup;
        `ADDR_VOLUME_MUTE:  reg_rdata_o <= volume_mute;
        default:            reg_rdata_o <= `RDATA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame-aligned copies of the routing fields, so a frame never sees a
  // half-changed configuration. They start from the register reset
  // fields, so the first frame sees the settings that a read reports.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_live  <= `RST_SEL_LIVE;
      path_live <= `RST_PATH_LIVE;
    end else if (frame_start_i) begin
      sel_live  <= sel_new;
      path_live <= path_setup[`PATH_MSB:`PATH_LSB];
    end
  end

  // Decode the live select code onto the engine or a fixed block.
  // Reserved codes select neither; output then carries no block.
  // Registering the decode keeps comparator glitches off the outputs.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      engine_select_o <= 1'b0;
      fixed_block_o   <= `BLOCK_NONE;
    end else begin
      engine_select_o <= (sel_live == `SEL_ENGINE);
      if ((sel_live >= `SEL_BLK4 && sel_live <= `SEL_BLK6) ||
          (sel_live >= `SEL_BLK12 && sel_live <= `SEL_BLK16) ||
          (sel_live >= `SEL_BLK20 && sel_live <= `SEL_BLK22))
        fixed_block_o <= sel_live;
      else
        fixed_block_o <= `BLOCK_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine condition bits and per-frame counter restart.
  // The clear pulse trails the frame start by one edge and lasts a cycle.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aux_cond_a_o <= 1'b0;
      aux_cond_b_o <= 1'b0;
      pc_clear_o   <= 1'b0;
    end else begin
      aux_cond_a_o <= mode_control[`AUX_A_BIT];
      aux_cond_b_o <= mode_control[`AUX_B_BIT];
      pc_clear_o   <= frame_start_i &
                      ~mode_control[`PC_FREE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mono mix; the average keeps one extra bit so it cannot overflow.
  // Path off drives a zero sample rather than holding the last one.
  always @* begin
    mix_sum = {left_i[23], left_i} + {right_i[23], right_i};
    case (path_live)
      `PATH_LEFT:  next_mono = left_i;
      `PATH_RIGHT: next_mono = right_i;
      `PATH_AVG:   next_mono = mix_sum[24:1];
      default:     next_mono = 24'h000000;
    endcase
  end

  // Sample register, power and mute outputs.
  // Power and mute trail their register bits by one edge, matching the
  // latency of the other decoded controls.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mono_o     <= 24'h000000;
      power_up_o <= 1'b0;
      mute_o     <= 1'b1;
    end else begin
      if (sample_tick_i)
        mono_o <= next_mono;
      power_up_o <= path_setup[`POWER_BIT];
      mute_o     <= volume_mute[`MUTE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Volume soft-stepping toward the requested target.
  // Code 11 is reserved; it freezes the volume rather than guess a rate.
  always @* begin
    case (step_code)
      `STEP_EVERY:     step_due = sample_tick_i;
      `STEP_EVERY_TWO: step_due = sample_tick_i & step_half;
      default:         step_due = 1'b0;
    endcase
  end

  // Signed chase toward the target; a target that moves mid-ramp is
  // simply followed from wherever the volume stands.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_half    <= 1'b0;
      volume_now_o <= 8'h00;
    end else begin
      if (sample_tick_i)
        step_half <= ~step_half;
      if (step_code == `STEP_NONE)
        volume_now_o <= volume_target_i;
      else if (step_due &&
               $signed(volume_now_o) < $signed(volume_target_i))
        volume_now_o <= volume_now_o + `VOL_STEP;
      else if (step_due &&
               $signed(volume_now_o) > $signed(volume_target_i))
        volume_now_o <= volume_now_o - `VOL_STEP;
    end
  end

endmodule

`default_nettype wire

//--- dac_path_ctrl_monitor.sv
/* Assertions on the path control bank ports.
   Assumes it is bound into every dac_path_ctrl instance. */
`timescale 1ns/100ps
`default_nettype none
module dac_path_ctrl_monitor (
  // Inputs.
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       frame_start_i,
  // Outputs.
  input wire logic       engine_select_o,
  input wire logic [4:0] fixed_block_o,
  input wire logic       aux_cond_a_o,
  input wire logic       aux_cond_b_o,
  input wire logic       pc_clear_o,
  input wire logic       power_up_o,
  input wire logic       mute_o
);
  // One clock domain, so reset gates every check.
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_aux_a_copy: assert property (reg_wr_i && reg_addr_i == 7'h3e |->
    ##2 aux_cond_a_o == $past(reg_wdata_i[2], 2)) else $error("aux a");
  a_aux_b_copy: assert property (reg_wr_i && reg_addr_i == 7'h3e |->
    ##2 aux_cond_b_o == $past(reg_wdata_i[1], 2)) else $error("aux b");
  a_power_copy: assert property (reg_wr_i && reg_addr_i == 7'h3f |->
    ##2 power_up_o == $past(reg_wdata_i[7], 2)) else $error("power");
  a_mute_copy: assert property (reg_wr_i && reg_addr_i == 7'h40 |->
    ##2 mute_o == $past(reg_wdata_i[3], 2)) else $error("mute");
  a_pc_clear_cause: assert property (pc_clear_o |->
    $past(frame_start_i)) else $error("counter clear");
  a_engine_no_block: assert property (engine_select_o |->
    fixed_block_o == 5'h00) else $error("engine with block");
  a_block_legal: assert property (fixed_block_o inside {5'h00,
    [5'h04:5'h06], [5'h0c:5'h10], [5'h14:5'h16]}) else $error("block code");
  a_block_at_frame: assert property ($changed(fixed_block_o) |->
    $past(frame_start_i, 2)) else $error("block change off frame");
endmodule
bind dac_path_ctrl dac_path_ctrl_monitor u_mon (.*);
`default_nettype wire

//--- dac_path_ctrl_host.sv
/* Host model writing and reading the bank.
   Assumes the bench calls its tasks in turn. */
`timescale 1ns/100ps
`default_nettype none
module dac_path_ctrl_host (
  // Clock and read-back.
  input  wire logic       clock_i,
  input  wire logic [7:0] reg_rdata_i,
  // Write strobe, address and data.
  output var  logic       reg_wr_o,
  output var  logic [6:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o
);
  // One-cycle strobe; data is scrambled after so stale values never pass.
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= a == 7'h3c ? d & 8'h1f :
                   a == 7'h3d ? 8'h08 : d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // Read data is registered: taken at the second edge after the address.
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    repeat (2) @(posedge clock_i);
    d = reg_rdata_i;
  endtask
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end
endmodule
`default_nettype wire

//--- dac_path_ctrl_tb.sv
/* Self-checking bench for the path control bank.
   Assumes the host model drives every register access. */
`timescale 1ns/100ps
`default_nettype none
module dac_path_ctrl_tb;
  logic clock_i, rstn_i, frame_start_i, sample_tick_i, reg_wr_i;
  logic engine_select_o, aux_cond_a_o, aux_cond_b_o, pc_clear_o;
  logic power_up_o, mute_o;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, volume_target_i, volume_now_o, d;
  logic [23:0] left_i, right_i, mono_o;
  logic [4:0] fixed_block_o, blk;
  logic [4:0] codes [12] = '{0, 4, 5, 6, 12, 13, 14, 15, 16, 20, 21, 22};
  logic [6:0] ra [6] = '{7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h41};
  logic [7:0] rv [6] = '{8'h01, 8'h08, 8'h00, 8'h14, 8'h0c, 8'h00};
  int n_mismatch = 0, checks = 0;
  dac_path_ctrl u_dut (.*);
  dac_path_ctrl_host u_host (.clock_i, .reg_rdata_i(reg_rdata_o),
    .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Frame start when f is set, otherwise a sample tick.
  task pulse(input logic f);
    @(posedge clock_i);
    frame_start_i <= f;
    sample_tick_i <= !f;
    @(posedge clock_i);
    frame_start_i <= 1'b0;
    sample_tick_i <= 1'b0;
    #1;
  endtask
  task settle;
    @(posedge clock_i);
    #1;
  endtask
  // Average keeps the carry so large samples do not wrap.
  function logic [23:0] mix(input logic [1:0] p, input logic [23:0] l, r);
    logic [24:0] s;
    s = {l[23], l} + {r[23], r};
    mix = p == 0 ? 24'h0 : p == 1 ? l : p == 2 ? r : s[24:1];
  endfunction
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    #500000 n_mismatch++;
    finish_test;
  end
  initial begin
    {rstn_i, frame_start_i, sample_tick_i, left_i, right_i} = '0;
    volume_target_i = 8'h00;
    blk = 5'h00;
    void'($urandom(32));
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    foreach (ra[i]) begin
      u_host.rd(ra[i], d);
      chk("reset value", rv[i], d);
    end
    chk("mute", 1, mute_o);
    u_host.wr(7'h41, 8'h5a);
    u_host.rd(7'h41, d);
    chk("unmapped", 0, d);
    repeat (8) begin
      d = 8'($urandom) & 8'h07;
      u_host.wr(7'h3e, d);
      settle;
      chk("aux a", d[2], aux_cond_a_o);
      chk("aux b", d[1], aux_cond_b_o);
      pulse(1);
      chk("counter clear", !d[0], pc_clear_o);
    end
    foreach (codes[i]) begin
      u_host.wr(7'h3c, {3'h0, codes[i]});
      settle;
      chk("block held", blk, fixed_block_o);
      pulse(1);
      settle;
      blk = codes[i];
      chk("engine", codes[i] == 0, engine_select_o);
      chk("block", blk, fixed_block_o);
    end
    for (int p = 0; p < 8; p++) begin
      u_host.wr(7'h3f, 8'h86 | (p[1:0] << 4));
      settle;
      chk("power", 1, power_up_o);
      pulse(1);
      @(posedge clock_i);
      // Full-scale pair last: the average must not wrap.
      left_i <= p == 7 ? 24'h7fffff : 24'($urandom);
      right_i <= p == 7 ? 24'h7fffff : 24'($urandom);
      pulse(0);
      settle;
      chk("mono", mix(p[1:0], left_i, right_i), mono_o);
    end
    u_host.wr(7'h3f, 8'h10);
    volume_target_i <= 8'h03;
    settle;
    chk("power", 0, power_up_o);
    for (int n = 1; n < 3; n++) begin
      pulse(0);
      settle;
      chk("volume", n, volume_now_o);
    end
    // Code 01 must climb only one step per two ticks.
    u_host.wr(7'h3f, 8'h11);
    volume_target_i <= 8'h06;
    repeat (2) pulse(0);
    settle;
    chk("volume", 3, volume_now_o);
    repeat (2) pulse(0);
    settle;
    chk("volume", 4, volume_now_o);
    u_host.wr(7'h3f, 8'h12);
    volume_target_i <= 8'h0a;
    settle;
    chk("volume", 8'h0a, volume_now_o);
    u_host.wr(7'h40, 8'h04);
    settle;
    chk("mute", 0, mute_o);
    finish_test;
  end
endmodule
`default_nettype wire
